//--- hdl/tpc_pkg.sv
// Purpose: constants and types for the toggle and power-down register bank
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: printed offsets are register indices, byte address is index times 4
package tpc_pkg;
    localparam int TPC_NUM_CH = 16;
    // register indices and byte addresses
    localparam logic [7:0] TPC_IDX_TOG_HIGH = 8'h07;
    localparam logic [7:0] TPC_IDX_TOG_LOW = 8'h08;
    localparam logic [7:0] TPC_IDX_PWDN = 8'h09;
    localparam logic [7:0] TPC_IDX_SOFT = 8'h0e;
    localparam logic [11:0] TPC_ADDR_TOG_HIGH = {2'b00, TPC_IDX_TOG_HIGH, 2'b00};
    localparam logic [11:0] TPC_ADDR_TOG_LOW = {2'b00, TPC_IDX_TOG_LOW, 2'b00};
    localparam logic [11:0] TPC_ADDR_PWDN = {2'b00, TPC_IDX_PWDN, 2'b00};
    localparam logic [11:0] TPC_ADDR_SOFT = {2'b00, TPC_IDX_SOFT, 2'b00};
    // reset values
    localparam logic [15:0] TPC_RST_TOG = 16'h0000;
    localparam logic [15:0] TPC_RST_PWDN = 16'hffff;
    localparam logic [2:0] TPC_RST_SOFT = 3'h0;
    // soft switch bit positions and soft enable position
    localparam int TPC_SOFT_LSB = 5;
    localparam int TPC_SOFT_EN_BIT = 8;
    // toggle selection codes
    typedef enum logic [1:0]
    {
        TPC_SEL_OFF = 2'h0,
        TPC_SEL_SRC0 = 2'h1,
        TPC_SEL_SRC1 = 2'h2,
        TPC_SEL_SRC2 = 2'h3
    } tpc_sel_t;
    typedef struct packed
    {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tpc_apb_req_t;
    typedef struct packed
    {
        logic [TPC_NUM_CH-1:0] tog_en;
        logic [TPC_NUM_CH-1:0] sel_b;
        logic [TPC_NUM_CH-1:0] pwdn;
    } tpc_chan_t;
endpackage

//--- hdl/tpc_chan_decode.sv
// Purpose: per-channel toggle source decode
// Assumes: pins synchronous to mclk_i
// Notes: purely combinational, one channel
`timescale 1ns/100ps
module tpc_chan_decode
(
    // channel field
    input wire logic [1:0] sel_i,
    // sources: pins 0..2 and soft bits 0..2
    input wire logic [2:0] pin_i,
    input wire logic [2:0] soft_i,
    input wire logic soft_en_i,
    // result
    output logic tog_en_o,
    output logic sel_b_o
);
    import tpc_pkg::*;
    logic [2:0] src;
    assign src = soft_en_i ? soft_i : pin_i;
    always_comb
    begin
        case (tpc_sel_t'(sel_i))
            TPC_SEL_SRC0:
            begin
                tog_en_o = 1'b1;
                sel_b_o = src[0];
            end
            TPC_SEL_SRC1:
            begin
                tog_en_o = 1'b1;
                sel_b_o = src[1];
            end
            TPC_SEL_SRC2:
            begin
                tog_en_o = 1'b1;
                sel_b_o = src[2];
            end
            default:
            begin
                tog_en_o = 1'b0;
                sel_b_o = 1'b0;
            end
        endcase
    end
endmodule

//--- hdl/tpc_regs.sv
// Purpose: toggle map and power-down register bank behind apb
// Assumes: single clock mclk_i, synchronous active-high reset
// Notes: one wait state, unmapped reads return zero with no error
//
// Our own choice: the APB register port.
`timescale 1ns/100ps
// Overview of operation
// - two-bit field selects toggle source zero-two
// - code zero disables toggle, reset disabled
// - high map holds channels 15 to 8
// - low map at 08h, channels 7-0
// - power-down bit per channel, one grounds output
// - power-down register at 09h, resets all ones
// - high map at 07h, resets zero
// - soft bits pick B or A per source
module tpc_regs
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // toggle pins
    input wire logic [2:0] dither_pin_i,
    // channel controls
    output tpc_pkg::tpc_chan_t chan_o
);
    import tpc_pkg::*;

    logic [15:0] toggle_map_high_channels;
    logic [15:0] toggle_map_low_channels;
    logic [15:0] channel_power_down_mask;
    logic [2:0] soft_ab_switch;
    logic soft_en;
    logic [2*TPC_NUM_CH-1:0] all_sel;
    logic [TPC_NUM_CH-1:0] next_tog_en;
    logic [TPC_NUM_CH-1:0] next_sel_b;
    logic wr_stb;
    logic rd_stb;
    logic [31:0] next_rdata;

    function automatic logic [31:0] rd_word(input logic [11:0] a,
        input logic [15:0] hi, input logic [15:0] lo, input logic [15:0] pd,
        input logic [2:0] sw, input logic en);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            TPC_ADDR_TOG_HIGH: w[15:0] = hi;
            TPC_ADDR_TOG_LOW: w[15:0] = lo;
            TPC_ADDR_PWDN: w[15:0] = pd;
            TPC_ADDR_SOFT:
            begin
                w[TPC_SOFT_LSB+2:TPC_SOFT_LSB] = sw;
                w[TPC_SOFT_EN_BIT] = en;
            end
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // access taken on the first access-phase edge, one cycle wide
    assign wr_stb = psel_i && penable_i && pwrite_i && !pready_o;
    assign rd_stb = psel_i && penable_i && !pwrite_i && !pready_o;

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            pready_o <= 1'b0;
        else
            pready_o <= psel_i && penable_i && !pready_o;
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            pslverr_o <= 1'b0;
        else
            pslverr_o <= 1'b0;
    end

    // each register written only at its own address, the whole register at once
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            toggle_map_high_channels <= TPC_RST_TOG;
        else if (wr_stb && paddr_i == TPC_ADDR_TOG_HIGH)
            toggle_map_high_channels <= pwdata_i[15:0];
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            toggle_map_low_channels <= TPC_RST_TOG;
        else if (wr_stb && paddr_i == TPC_ADDR_TOG_LOW)
            toggle_map_low_channels <= pwdata_i[15:0];
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            channel_power_down_mask <= TPC_RST_PWDN;
        else if (wr_stb && paddr_i == TPC_ADDR_PWDN)
            channel_power_down_mask <= pwdata_i[15:0];
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            soft_ab_switch <= TPC_RST_SOFT;
            soft_en <= 1'b0;
        end
        else if (wr_stb && paddr_i == TPC_ADDR_SOFT)
        begin
            soft_ab_switch <= pwdata_i[TPC_SOFT_LSB+2:TPC_SOFT_LSB];
            soft_en <= pwdata_i[TPC_SOFT_EN_BIT];
        end
    end

    assign next_rdata = rd_word(paddr_i, toggle_map_high_channels,
        toggle_map_low_channels, channel_power_down_mask, soft_ab_switch,
        soft_en);

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            prdata_o <= 32'h0000_0000;
        else if (rd_stb)
            prdata_o <= next_rdata;
    end

    // channel 15 in bits 31-30 of the joined maps, channel 0 in bits 1-0
    assign all_sel = {toggle_map_high_channels, toggle_map_low_channels};

    genvar g;
    generate
        for (g = 0; g < TPC_NUM_CH; g++)
        begin : g_ch
            tpc_chan_decode u_dec
            (
                .sel_i(all_sel[2*g+1:2*g]),
                .pin_i(dither_pin_i),
                .soft_i(soft_ab_switch),
                .soft_en_i(soft_en),
                .tog_en_o(next_tog_en[g]),
                .sel_b_o(next_sel_b[g])
            );
        end
    endgenerate

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            chan_o <= '{tog_en: '0, sel_b: '0, pwdn: TPC_RST_PWDN};
        else
        begin
            chan_o.tog_en <= next_tog_en;
            chan_o.sel_b <= next_sel_b;
            chan_o.pwdn <= channel_power_down_mask;
        end
    end

    // checks
    sequence s_write(logic [11:0] a);
        psel_i && penable_i && pwrite_i && !pready_o && paddr_i == a;
    endsequence

    property p_pwdn_reset;
        @(posedge mclk_i) $fell(srst_i) |-> channel_power_down_mask == 16'hffff;
    endproperty
    a_pwdn_reset: assert property (p_pwdn_reset) else $error("pwdn reset");

    property p_tog_reset;
        @(posedge mclk_i) $fell(srst_i) |->
            toggle_map_high_channels == 16'h0000 &&
            toggle_map_low_channels == 16'h0000;
    endproperty
    a_tog_reset: assert property (p_tog_reset) else $error("tog reset");

    property p_high_write;
        @(posedge mclk_i) disable iff (srst_i)
        s_write(12'h01c) |=> toggle_map_high_channels == $past(pwdata_i[15:0]);
    endproperty
    a_high_write: assert property (p_high_write) else $error("high wr");

    property p_low_write;
        @(posedge mclk_i) disable iff (srst_i)
        s_write(12'h020) |=> toggle_map_low_channels == $past(pwdata_i[15:0]);
    endproperty
    a_low_write: assert property (p_low_write) else $error("low wr");

    property p_pwdn_write;
        @(posedge mclk_i) disable iff (srst_i)
        s_write(12'h024) |=> ##1 chan_o.pwdn == $past(pwdata_i[15:0], 2);
    endproperty
    a_pwdn_write: assert property (p_pwdn_write) else $error("pd wr");

    property p_ch15_off;
        @(posedge mclk_i) disable iff (srst_i)
        toggle_map_high_channels[15:14] == 2'h0 |=> !chan_o.tog_en[15];
    endproperty
    a_ch15_off: assert property (p_ch15_off) else $error("ch15 on");

    property p_ch3_src2_soft;
        @(posedge mclk_i) disable iff (srst_i)
        toggle_map_low_channels[7:6] == 2'h3 && soft_en |=>
            chan_o.tog_en[3] && chan_o.sel_b[3] == $past(soft_ab_switch[2]);
    endproperty
    a_ch3_src2_soft: assert property (p_ch3_src2_soft) else $error("ch3");

    property p_ch10_src0;
        @(posedge mclk_i) disable iff (srst_i)
        toggle_map_high_channels[5:4] == 2'h1 && !soft_en |=>
            chan_o.tog_en[10] && chan_o.sel_b[10] == $past(dither_pin_i[0]);
    endproperty
    a_ch10_src0: assert property (p_ch10_src0) else $error("ch10");

    // a low map write must leave the power-down and high map registers alone
    property p_other_stable;
        @(posedge mclk_i) disable iff (srst_i)
        s_write(TPC_ADDR_TOG_LOW) |=> $stable(channel_power_down_mask) &&
            $stable(toggle_map_high_channels);
    endproperty
    a_other_stable: assert property (p_other_stable) else $error("indep");
endmodule

//--- tb/tpc_regs_tb_top.sv
// Purpose: self-checking bench for the toggle and power-down register bank
// Assumes: apb slave answers with pready_o, the wait is bounded, not assumed
// Notes: pin and soft toggle sources are swept through all eight values
`timescale 1ns/100ps
module tpc_regs_tb_top;
    import tpc_pkg::*;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [2:0] dither_pin_i = 3'h0;
    tpc_chan_t chan_o;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic slverr;
    logic [15:0] lo = 16'he4e4;
    logic [15:0] hi = 16'h1b1b;
    logic [15:0] exp_en;

    always #5 mclk_i = ~mclk_i;

    tpc_regs uut
    (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .dither_pin_i(dither_pin_i),
        .chan_o(chan_o)
    );

    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        penable_i <= 1'b0;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do
            @(posedge mclk_i);
        while (pready_o !== 1'b1);
        rd = prdata_o;
        slverr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, {16'h0000, exp});
    endtask

    // each enabled channel must follow its selected source bit
    task automatic check_sel(input logic [2:0] s);
        logic [1:0] code;
        repeat (2) @(posedge mclk_i);
        for (int ch = 0; ch < 16; ch++)
        begin
            code = (ch < 8) ? lo[2*ch+:2] : hi[2*(ch-8)+:2];
            if (code != 2'h0)
                chk({31'h0, chan_o.sel_b[ch]}, {31'h0, s[code-1]});
        end
    endtask

    task automatic check_en();
        for (int ch = 0; ch < 16; ch++)
            exp_en[ch] = (ch < 8) ? |lo[2*ch+:2] : |hi[2*(ch-8)+:2];
        chk({16'h0000, chan_o.tog_en}, {16'h0000, exp_en});
    endtask

    initial
    begin
        repeat (4) @(posedge mclk_i);
        srst_i <= 1'b0;
        rd_chk(TPC_ADDR_TOG_HIGH, 16'h0000);
        rd_chk(TPC_ADDR_TOG_LOW, 16'h0000);
        rd_chk(TPC_ADDR_PWDN, 16'hffff);
        chk({16'h0000, chan_o.tog_en}, 32'h0000_0000);
        chk({16'h0000, chan_o.pwdn}, 32'h0000_ffff);
        apb(1'b1, TPC_ADDR_TOG_HIGH, {16'h0000, hi});
        apb(1'b1, TPC_ADDR_TOG_LOW, {16'h0000, lo});
        rd_chk(TPC_ADDR_TOG_HIGH, hi);
        rd_chk(TPC_ADDR_TOG_LOW, lo);
        check_en();
        for (int v = 0; v < 8; v++)
        begin
            dither_pin_i <= v[2:0];
            check_sel(v[2:0]);
        end
        // soft bits win while pins show the opposite pattern
        for (int v = 0; v < 8; v++)
        begin
            dither_pin_i <= ~v[2:0];
            apb(1'b1, TPC_ADDR_SOFT, {23'h0, 1'b1, v[2:0], 5'h00});
            check_sel(v[2:0]);
        end
        rd_chk(TPC_ADDR_SOFT, 16'h01e0);
        apb(1'b1, TPC_ADDR_SOFT, 32'h0000_0000);
        rd_chk(TPC_ADDR_SOFT, 16'h0000);
        // move channel 5 alone from source zero to source one
        lo = lo ^ 16'h0c00;
        apb(1'b1, TPC_ADDR_TOG_LOW, {16'h0000, lo});
        rd_chk(TPC_ADDR_TOG_HIGH, hi);
        check_en();
        dither_pin_i <= 3'h2;
        check_sel(3'h2);
        apb(1'b1, TPC_ADDR_PWDN, 32'h0000_5a3c);
        rd_chk(TPC_ADDR_PWDN, 16'h5a3c);
        chk({16'h0000, chan_o.pwdn}, 32'h0000_5a3c);
        apb(1'b1, TPC_ADDR_PWDN, 32'h0000_5a3d);
        @(posedge mclk_i);
        chk({16'h0000, chan_o.pwdn}, 32'h0000_5a3d);
        rd_chk(TPC_ADDR_TOG_LOW, lo);
        apb(1'b1, 12'h03c, 32'hffff_ffff);
        chk({31'h0, slverr}, 32'h0000_0000);
        rd_chk(12'h03c, 16'h0000);
        chk({31'h0, slverr}, 32'h0000_0000);
        rd_chk(TPC_ADDR_PWDN, 16'h5a3d);
        apb(1'b1, TPC_ADDR_SOFT, 32'h0000_01e0);
        // second reset in mid-run restores defaults
        @(posedge mclk_i);
        srst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        srst_i <= 1'b0;
        rd_chk(TPC_ADDR_TOG_LOW, 16'h0000);
        rd_chk(TPC_ADDR_TOG_HIGH, 16'h0000);
        chk({16'h0000, chan_o.pwdn}, 32'h0000_ffff);
        chk({16'h0000, chan_o.tog_en}, 32'h0000_0000);
        rd_chk(TPC_ADDR_SOFT, 16'h0000);
        test_done();
    end
endmodule
